// File: src/ext_port_pkg.sv
package ext_port_pkg;
	localparam int ADDR_W    = 18;
	localparam int DATA_W    = 8;
	localparam int WAIT_W    = 5;
	localparam int ATTR_W    = 2;
	// Register port map (word index on the plain register port)
	localparam logic [3:0] REG_WAIT_CTRL  = 4'h0;
	localparam logic [3:0] REG_MODE       = 4'h1;
	localparam logic [3:0] REG_STATUS     = 4'h2;
	// Bit positions inside the mode register
	localparam int MODE_SYNC_BIT   = 0;
	localparam int MODE_ROW_BIT    = 1;
	localparam int MODE_POL0_BIT   = 2;
	localparam int MODE_POL1_BIT   = 3;
	localparam int MODE_W          = 4;
	// Reset values
	localparam logic [WAIT_W-1:0] WAIT_RESET = 5'h01;
	localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_ACK   = 2'b10,
		ST_DONE  = 2'b11
	} bus_state_e;
endpackage

// File: src/ext_memory_port.sv
`timescale 1ns/1ps
module ext_memory_port
	import ext_port_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              standby_i,
	input  wire logic              req_i,
	input  wire logic              req_write_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	input  wire logic [DATA_W-1:0] req_wdata_i,
	input  wire logic [ATTR_W-1:0] req_attr_i,
	output logic                   req_ready_o,
	output logic                   done_o,
	output logic      [DATA_W-1:0] rdata_o,
	input  wire logic [3:0]        reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	input  wire logic              reg_write_i,
	input  wire logic              reg_read_i,
	output logic      [7:0]        reg_rdata_o,
	output logic      [ADDR_W-1:0] ext_addr_bus_o,
	input  wire logic [DATA_W-1:0] ext_data_bus_i,
	output logic      [DATA_W-1:0] ext_data_bus_o,
	output logic                   ext_data_bus_oe_o,
	output logic      [ATTR_W-1:0] attribute_select_o,
	output logic                   attribute_select_oe_o,
	output logic                   col_strobe_n_o,
	output logic                   read_strobe_n_o,
	output logic                   write_strobe_n_o,
	output logic                   ctrl_oe_o,
	input  wire logic              transfer_ack_n_i
);

	typedef struct packed {
		bus_state_e        state;
		logic [WAIT_W-1:0] min_wait;
		logic [MODE_W-1:0] mode;
		logic [WAIT_W-1:0] wait_cnt;
		logic              write;
		logic [ATTR_W-1:0] attr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic              done;
		logic              ack_meta;
		logic              ack_sync;
		logic [7:0]        reg_rdata;
	} state_s;

	state_s cur;
	state_s next_cur;

	function automatic logic [ATTR_W-1:0] apply_pol(
		input logic [ATTR_W-1:0] v,
		input logic [MODE_W-1:0] m
	);
		apply_pol = v ^ {m[MODE_POL1_BIT], m[MODE_POL0_BIT]};
	endfunction

	logic ack_seen;
	logic active;

	always_comb begin
		// Async mode reads only the second synchronizer stage
		ack_seen = cur.mode[MODE_SYNC_BIT] ? !transfer_ack_n_i
			: cur.ack_sync;
		active = (cur.state != ST_IDLE);
	end

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.ack_meta = !transfer_ack_n_i;
		next_cur.ack_sync = cur.ack_meta;
		next_cur.reg_rdata = 8'h00;
		if (reg_read_i) begin
			case (reg_addr_i)
				REG_WAIT_CTRL: next_cur.reg_rdata = 8'(cur.min_wait);
				REG_MODE:      next_cur.reg_rdata = 8'(cur.mode);
				REG_STATUS:    next_cur.reg_rdata = 8'({active});
				default:       next_cur.reg_rdata = 8'h00;
			endcase
		end
		if (reg_write_i) begin
			case (reg_addr_i)
				REG_WAIT_CTRL: next_cur.min_wait = reg_wdata_i[WAIT_W-1:0];
				REG_MODE:      next_cur.mode = reg_wdata_i[MODE_W-1:0];
				default:       ;
			endcase
		end
		case (cur.state)
			ST_IDLE: begin
				// Address only changes when an access starts
				if (req_i && !standby_i) begin
					next_cur.addr = req_addr_i;
					next_cur.write = req_write_i;
					next_cur.wdata = req_wdata_i;
					next_cur.attr = req_attr_i;
					next_cur.wait_cnt = cur.min_wait;
					next_cur.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Programmed minimum first, then acknowledge may stretch
				if (cur.wait_cnt != '0) begin
					next_cur.wait_cnt = cur.wait_cnt - 1'b1;
				end else if (cur.min_wait == '0 || cur.mode[MODE_ROW_BIT]
						|| ack_seen) begin
					next_cur.state = ST_ACK;
				end
			end
			ST_ACK: begin
				// One clock after acknowledge the cycle ends
				if (!cur.write) begin
					next_cur.rdata = ext_data_bus_i;
				end
				next_cur.done = 1'b1;
				next_cur.state = ST_DONE;
			end
			ST_DONE: begin
				next_cur.state = ST_IDLE;
			end
			default: next_cur.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur <= '0;
			cur.state <= ST_IDLE;
			cur.min_wait <= WAIT_RESET;
			cur.mode <= MODE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	logic drive;
	logic strobe;
	always_comb begin
		drive = !rst_i && !standby_i;
		strobe = (cur.state == ST_WAIT) || (cur.state == ST_ACK);
		req_ready_o = (cur.state == ST_IDLE) && !standby_i;
		done_o = cur.done;
		rdata_o = cur.rdata;
		reg_rdata_o = cur.reg_rdata;
		ext_addr_bus_o = cur.addr;
		ext_data_bus_o = cur.wdata;
		ext_data_bus_oe_o = drive && strobe && cur.write;
		attribute_select_oe_o = drive;
		// Selects assert for the whole cycle, column strobe for the access
		attribute_select_o = apply_pol((strobe || cur.state == ST_DONE)
			? cur.attr : '0, cur.mode);
		ctrl_oe_o = drive;
		col_strobe_n_o = !(cur.mode[MODE_ROW_BIT] && strobe);
		read_strobe_n_o = !(strobe && !cur.write);
		write_strobe_n_o = !(strobe && cur.write);
	end

	// Acknowledge cannot start a cycle from idle
	a_idle_ack_ignored: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_IDLE && !(req_i && !standby_i)
		|=> cur.state == ST_IDLE)
		else $error("acknowledge affected idle bus");

	a_standby_float: assert property (
		@(posedge clk_i) disable iff (rst_i)
		standby_i |-> !ext_data_bus_oe_o && !ctrl_oe_o
		&& !attribute_select_oe_o)
		else $error("outputs driven in standby");

	a_reset_float: assert property (
		@(posedge clk_i)
		rst_i |-> !ext_data_bus_oe_o && !ctrl_oe_o)
		else $error("outputs driven in reset");

	a_reset_attr_float: assert property (
		@(posedge clk_i)
		rst_i |-> !attribute_select_oe_o)
		else $error("attributes driven in reset");

	a_addr_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state != ST_IDLE |=> $stable(ext_addr_bus_o))
		else $error("address changed during cycle");

	a_idle_addr_keep: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_IDLE && !(req_i && !standby_i)
		|=> $stable(ext_addr_bus_o))
		else $error("address toggled while idle");

	a_addr_load: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_IDLE && req_i && !standby_i
		|=> ext_addr_bus_o == $past(req_addr_i))
		else $error("address not loaded at start");

	a_ack_end: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_ACK |=> done_o ##1 cur.state == ST_IDLE)
		else $error("cycle did not end after acknowledge");

	a_pend_no_ack: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && cur.wait_cnt == '0 && !ack_seen
		&& cur.min_wait != '0 && !cur.mode[MODE_ROW_BIT]
		|=> cur.state == ST_WAIT)
		else $error("cycle ended without acknowledge");

	a_min_wait: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && cur.wait_cnt != '0
		|=> cur.state == ST_WAIT)
		else $error("minimum wait cut short");

	a_start_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_IDLE && req_i && !standby_i
		|=> cur.wait_cnt == $past(cur.min_wait))
		else $error("wait count not loaded from minimum");

	// Ways out of the wait state
	a_ack_proceeds: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && cur.wait_cnt == '0 && ack_seen
		|=> cur.state == ST_ACK)
		else $error("acknowledge did not end wait");

	a_zero_no_stretch: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && cur.wait_cnt == '0 && cur.min_wait == '0
		|=> cur.state == ST_ACK)
		else $error("zero wait access was stretched");

	a_row_no_stretch: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && cur.wait_cnt == '0 && cur.mode[MODE_ROW_BIT]
		|=> cur.state == ST_ACK)
		else $error("row strobe access was stretched");

	a_read_strobe: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!read_strobe_n_o |-> !cur.write && write_strobe_n_o)
		else $error("read and write strobes overlap");

	a_read_assert: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && !cur.write |-> !read_strobe_n_o)
		else $error("read strobe missing in read cycle");

	a_write_assert: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && cur.write |-> !write_strobe_n_o)
		else $error("write strobe missing in write cycle");

	a_idle_strobes: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_IDLE |-> read_strobe_n_o && write_strobe_n_o
		&& col_strobe_n_o)
		else $error("strobe active while idle");

	a_done_strobes: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_DONE |-> read_strobe_n_o && write_strobe_n_o)
		else $error("strobe active after cycle end");

	a_cas_row_only: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!col_strobe_n_o |-> cur.mode[MODE_ROW_BIT])
		else $error("column strobe outside row mode");

	a_cas_in_cycle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.mode[MODE_ROW_BIT] && cur.state == ST_ACK |-> !col_strobe_n_o)
		else $error("column strobe missing in row cycle");

	// Data bus direction and content
	a_write_drive: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_WAIT && cur.write && !standby_i |-> ext_data_bus_oe_o)
		else $error("data bus not driven in write");

	a_read_release: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!cur.write |-> !ext_data_bus_oe_o)
		else $error("data bus driven in read");

	a_wdata_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state != ST_IDLE |=> $stable(ext_data_bus_o))
		else $error("write data changed during cycle");

	a_read_capture: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_ACK && !cur.write |=> rdata_o == $past(ext_data_bus_i))
		else $error("read data not captured");

	a_attr_idle_level: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_IDLE |-> attribute_select_o
		== {cur.mode[MODE_POL1_BIT], cur.mode[MODE_POL0_BIT]})
		else $error("attribute idle level wrong");

	a_attr_drive: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!standby_i |-> attribute_select_oe_o)
		else $error("attributes floating when active");

	a_ctrl_drive: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!standby_i |-> ctrl_oe_o)
		else $error("strobes floating when active");

	// Acknowledge paths
	a_sync_direct: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.mode[MODE_SYNC_BIT] |-> ack_seen != transfer_ack_n_i)
		else $error("synchronous acknowledge not direct");

	a_sync_two: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!cur.mode[MODE_SYNC_BIT] |-> ack_seen != $past(transfer_ack_n_i, 2))
		else $error("asynchronous acknowledge not two-stage");

	a_done_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		done_o |=> !done_o)
		else $error("done longer than one cycle");

	a_done_after_ack: assert property (
		@(posedge clk_i) disable iff (rst_i)
		done_o |-> $past(cur.state) == ST_ACK)
		else $error("done without acknowledge cycle");

	a_ready_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		req_ready_o |-> cur.state == ST_IDLE && !standby_i)
		else $error("ready while busy or in standby");

	a_standby_no_start: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cur.state == ST_IDLE && standby_i |=> cur.state == ST_IDLE)
		else $error("cycle started in standby");

endmodule // ext_memory_port

// File: testbench/mem_partner.sv
`timescale 1ns/1ps
module mem_partner
	import ext_port_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [7:0]        stall_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              ctrl_oe_i,
	input  wire logic              read_n_i,
	input  wire logic              write_n_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   ack_n_o
);
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] last = 8'h5a;
	logic [7:0]        cnt  = 8'h00;
	logic              busy;
	assign busy = ctrl_oe_i && !(read_n_i && write_n_i);
	// Held off for stall_i strobe cycles, released between cycles
	assign ack_n_o = !(busy && cnt >= stall_i);
	// A released bus shows the inverse of its last value
	assign rdata_o = (busy && !read_n_i) ? mem[addr_i[7:0]] : ~last;
	always_ff @(posedge clk_i) begin
		last <= rdata_o;
		cnt  <= busy ? cnt + 8'h01 : 8'h00;
		if (busy && !write_n_i)
			mem[addr_i[7:0]] <= wdata_i;
	end
endmodule // mem_partner

// File: testbench/ext_memory_port_tb.sv
`timescale 1ns/1ps
module ext_memory_port_tb;
	import ext_port_pkg::*;
	logic clk_i = 0, rst_i = 1, standby_i = 0, req_i = 0, req_write_i = 0;
	logic [17:0] req_addr_i = 0, ext_addr_bus_o;
	logic [7:0]  req_wdata_i = 0, reg_wdata_i = 0, stall = 0, rdata_o, rd, rv;
	logic [7:0]  reg_rdata_o, bus_in, ext_data_bus_o, mem_data;
	logic [3:0]  reg_addr_i = 0;
	logic [1:0]  req_attr_i = 2'b11, attribute_select_o, att;
	logic reg_write_i = 0, reg_read_i = 0, req_ready_o, done_o, rs, ws;
	logic oe, cs;
	logic ext_data_bus_oe_o, attribute_select_oe_o, ctrl_oe_o, ack_n;
	logic col_strobe_n_o, read_strobe_n_o, write_strobe_n_o;
	int mismatches = 0, comparisons = 0, lat, base;
	int st[3] = '{1, 5, 9};
	int ex[3] = '{0, 3, 7};
	assign bus_in = ext_data_bus_oe_o ? ext_data_bus_o : mem_data;
	always #12.5 clk_i = ~clk_i;
	ext_memory_port ext_memory_port_inst (.clk_i(clk_i), .rst_i(rst_i),
		.standby_i(standby_i), .req_i(req_i), .req_write_i(req_write_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
		.req_attr_i(req_attr_i), .req_ready_o(req_ready_o), .done_o(done_o),
		.rdata_o(rdata_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .ext_addr_bus_o(ext_addr_bus_o),
		.ext_data_bus_i(bus_in), .ext_data_bus_o(ext_data_bus_o),
		.ext_data_bus_oe_o(ext_data_bus_oe_o),
		.attribute_select_o(attribute_select_o),
		.attribute_select_oe_o(attribute_select_oe_o),
		.col_strobe_n_o(col_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
		.write_strobe_n_o(write_strobe_n_o), .ctrl_oe_o(ctrl_oe_o),
		.transfer_ack_n_i(ack_n));
	mem_partner mem_partner_inst (.clk_i(clk_i), .stall_i(stall),
		.addr_i(ext_addr_bus_o), .wdata_i(ext_data_bus_o),
		.ctrl_oe_i(ctrl_oe_o), .read_n_i(read_strobe_n_o),
		.write_n_i(write_strobe_n_o), .rdata_o(mem_data), .ack_n_o(ack_n));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask
	task automatic rrd(input logic [3:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		#1 rv = reg_rdata_o;
	endtask
	task automatic acc(input logic w, input logic [17:0] a,
		input logic [7:0] d);
		@(posedge clk_i);
		req_i <= 1'b1;
		req_write_i <= w;
		req_addr_i <= a;
		req_wdata_i <= d;
		@(posedge clk_i);
		req_i <= 1'b0;
		lat = 0;
		rs = 0;
		ws = 0;
		oe = 0;
		cs = 0;
		while (done_o !== 1'b1 && lat < 200) begin
			@(posedge clk_i);
			#1 lat++;
			if (read_strobe_n_o === 1'b0) rs = 1;
			if (write_strobe_n_o === 1'b0) ws = 1;
			if (ext_data_bus_oe_o === 1'b1) oe = 1;
			if (col_strobe_n_o === 1'b0) cs = 1;
			if (!(read_strobe_n_o & write_strobe_n_o)) att = attribute_select_o;
		end
		rd = rdata_o;
		chk(ext_addr_bus_o, a);
		chk({rs, ws, oe}, {!w, w, w});
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		results();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		chk({ctrl_oe_o, ext_data_bus_oe_o, attribute_select_oe_o},
			0);
		rst_i <= 1'b0;
		rrd(REG_WAIT_CTRL);
		chk(rv, WAIT_RESET);
		rrd(REG_MODE);
		chk(rv, MODE_RESET);
		rrd(4'hf);
		chk(rv, 0);
		wr(REG_WAIT_CTRL, 8'h02);
		wr(REG_MODE, 8'h05);
		rrd(REG_MODE);
		chk(rv, 8'h05);
		$display("test registers done");
		acc(1, 18'h2a5c3, 8'h96);
		chk(att, 2'b10);
		chk(cs, 0);
		acc(0, 18'h2a5c3, 8'h00);
		chk(rd, 8'h96);
		base = lat;
		repeat (5) @(posedge clk_i);
		#1 chk(ext_addr_bus_o, 18'h2a5c3);
		$display("test access done");
		// Stretch only with a nonzero minimum and no row strobes
		for (int i = 0; i < 3; i++) begin
			stall <= st[i];
			acc(0, 18'h00100, 8'h00);
			chk(lat, base + ex[i]);
		end
		// Two synchronizer stages add two cycles
		wr(REG_MODE, 8'h04);
		acc(0, 18'h00100, 8'h00);
		chk(lat, base + 9);
		// Row strobe cycles end without acknowledge
		wr(REG_MODE, 8'h07);
		acc(0, 18'h00100, 8'h00);
		chk(lat, base);
		chk(cs, 1);
		// Zero minimum ends without acknowledge, upper polarity bit
		wr(REG_WAIT_CTRL, 8'h00);
		wr(REG_MODE, 8'h09);
		acc(0, 18'h00100, 8'h00);
		chk(lat, base - 2);
		chk(att, 2'b01);
		stall <= 0;
		$display("test latency done");
		@(posedge clk_i) standby_i <= 1'b1;
		@(posedge clk_i);
		#1 chk({req_ready_o, ctrl_oe_o, ext_data_bus_oe_o,
			attribute_select_oe_o}, 0);
		@(posedge clk_i) standby_i <= 1'b0;
		$display("test standby done");
		results();
	end
endmodule // ext_memory_port_tb
